// [rtl/modbus_rtu_pkg.sv]
// Constants and helpers for the serial command interpreter
package modbus_rtu_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [15:0] BIT_CYCLES_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  // Silence of 3.5 characters of 10 bits each, in bit times
  localparam logic [21:0] GAP_BITS = 22'd35;
  localparam logic [3:0] STOP_BIT_IDX = 4'd9;
  // ==========================================================
  // Frame layout
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_FRAME = 8'h03;
  localparam logic [15:0] DIAG_LOOPBACK = 16'h0000;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [6:0] LEN_FIXED = 7'h08;
  localparam logic [6:0] LEN_WRN_BASE = 7'h09;
  localparam logic [6:0] LEN_MIN = 7'h04;
  localparam logic [6:0] LEN_ECHO = 7'h06;
  localparam logic [6:0] LEN_EXC = 7'h03;
  localparam logic [6:0] LEN_RD_HDR = 7'h03;
  localparam int unsigned BUF_DEPTH = 64;
  localparam logic [6:0] BUF_FULL = 7'h40;
  // ==========================================================
  // Check field
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step
endpackage : modbus_rtu_pkg

// [rtl/modbus_rtu_slave.sv]
// Modbus RTU slave: framing, check field, decode and response
// Functional notes
// - Characters are start, eight data, stop; bit time set by baud_div.
// - Frames are delimited by more than 3.5 character times of silence.
// - Frame holds station byte, function byte, data, then check field.
// - Station 1 to 247 is unicast, zero is broadcast.
// - Functions 0x03, 0x06, 0x10 and diagnostic 0x08 are served.
// - Two-byte CRC-16 over the message is checked and appended.
// - Read carries start and count 1 to 16, high byte first.
// - Read reply gives byte count twice count, then values high first.
// - Read span crossing its parameter group is answered with an error.
// - Write-single echoes function, address and value.
// - Write-multiple checks count and byte count, replies start and count.
// - Diagnostic loopback 0x0000 echoes subcommand and data unchanged.
// - Diagnostics touch no register and no other behaviour.
// - Unservable request answered with function plus 0x80 and a code.
// - Framing, station or check fault gives no reply at all.
// - Exception codes: 0x01 function, 0x02 address or count, 0x03 length.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  input wire logic [7:0] station_addr,
  input wire logic [15:0] baud_div,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  output logic reg_wr,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] reg_status
);
  import modbus_rtu_pkg::*;

  typedef enum logic [2:0] {S_RX, S_DECODE, S_REG, S_WAIT, S_SEND} st_type;
  st_type st_r;

  // ==========================================================
  // Line input synchroniser
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= line_in;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) rx_lvl_r <= rx_s3_r;
    end
  end

  // ==========================================================
  // Character receiver
  logic rx_busy_r, rx_done_r, rx_ferr_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_ferr_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        // Half duplex: nothing is heard while a request is in work
        if (st_r == S_RX && !rx_lvl_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= baud_div >> 1;
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != 16'h0000) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= baud_div - 16'h0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rx_lvl_r) begin
          rx_busy_r <= 1'b0;
        end else if (rx_bit_r == STOP_BIT_IDX) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= 1'b1;
          rx_ferr_r <= !rx_lvl_r;
        end else if (rx_bit_r != 4'h0) begin
          rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // Silence timer and frame delimiting
  logic [21:0] gap_cyc_r;
  logic [21:0] gap_lim;
  logic gap_full;
  logic in_frame_r, frame_end_r;
  logic lead_gap_r;
  assign gap_lim = 22'(baud_div) * GAP_BITS;
  assign gap_full = gap_cyc_r > gap_lim;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_cyc_r <= 22'h000000;
      lead_gap_r <= 1'b0;
      in_frame_r <= 1'b0;
      frame_end_r <= 1'b0;
    end else begin
      frame_end_r <= 1'b0;
      // line must be quiet, including our own driving
      if (!rx_lvl_r || rx_busy_r || !line_oe_n) gap_cyc_r <= 22'h000000;
      else if (!gap_full) gap_cyc_r <= gap_cyc_r + 22'h000001;
      // Counter clears once a character starts, so keep its verdict
      if (!rx_busy_r) lead_gap_r <= gap_full;
      if (rx_done_r) in_frame_r <= 1'b1;
      // end of frame on long silence
      else if (in_frame_r && gap_full && st_r == S_RX) begin
        in_frame_r <= 1'b0;
        frame_end_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Request buffer and check accumulator
  logic [7:0] rxb [0:BUF_DEPTH-1];
  logic [6:0] rx_len_r;
  logic rx_bad_r;
  logic [15:0] rx_crc_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_len_r <= 7'h00;
      rx_bad_r <= 1'b0;
      rx_crc_r <= CRC_INIT;
    end else if (rx_done_r) begin
      if (!in_frame_r) begin
        // a first byte not preceded by silence spoils the frame
        rxb[0] <= rx_sh_r;
        rx_len_r <= 7'h01;
        rx_bad_r <= rx_ferr_r || !lead_gap_r;
        // residue of whole frame is zero when intact
        rx_crc_r <= crc_step(CRC_INIT, rx_sh_r);
      end else if (rx_len_r == BUF_FULL) begin
        rx_bad_r <= 1'b1;
      end else begin
        rxb[rx_len_r[5:0]] <= rx_sh_r;
        rx_len_r <= rx_len_r + 7'h01;
        rx_bad_r <= rx_bad_r || rx_ferr_r;
        rx_crc_r <= crc_step(rx_crc_r, rx_sh_r);
      end
    end
  end

  // ==========================================================
  // Request decode
  logic [7:0] fn;
  logic [15:0] f_a, f_n;
  logic bcast, drop, n_ok;
  logic [7:0] exc;
  logic [8:0] span;
  logic [4:0] op_n;
  assign fn = rxb[1];
  assign f_a = {rxb[2], rxb[3]};
  assign f_n = {rxb[4], rxb[5]};
  assign bcast = rxb[0] == ADDR_BCAST;
  // station range; check residue; silent drop
  assign drop = rx_bad_r || rx_len_r < LEN_MIN || rx_crc_r != 16'h0000
    || rxb[0] > ADDR_MAX || !(bcast || rxb[0] == station_addr);
  assign n_ok = f_n != 16'h0000 && f_n <= MAX_REGS;
  // low byte is the index inside a group; no carry allowed
  assign span = {1'b0, f_a[7:0]} + {4'h0, f_n[4:0]} - 9'h001;
  assign op_n = (fn == FN_WRITE1) ? 5'h01 : f_n[4:0];

  always_comb begin
    exc = 8'h00;
    case (fn)
      FN_READ: begin
        if (rx_len_r != LEN_FIXED) exc = EXC_FRAME;
        else if (!n_ok || span[8]) exc = EXC_ADDR;
      end
      FN_WRITE1: begin
        if (rx_len_r != LEN_FIXED) exc = EXC_FRAME;
      end
      FN_WRITEN: begin
        // byte count must be twice the count
        if (!n_ok || rxb[6] != {2'b00, f_n[4:0], 1'b0}) exc = EXC_ADDR;
        else if (rx_len_r != LEN_WRN_BASE + {1'b0, f_n[4:0], 1'b0})
          exc = EXC_FRAME;
      end
      FN_DIAG: begin
        if (rx_len_r != LEN_FIXED) exc = EXC_FRAME;
        else if (f_a != DIAG_LOOPBACK)
          exc = EXC_FUNC;
      end
      default: exc = EXC_FUNC;
    endcase
  end

  // ==========================================================
  // Sequencer and response buffer
  logic [7:0] txb [0:BUF_DEPTH-1];
  logic [6:0] tx_len_r;
  logic [4:0] idx_r;
  logic tx_done_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= S_RX;
      tx_len_r <= 7'h00;
      idx_r <= 5'h00;
    end else begin
      case (st_r)
        S_RX: begin
          if (frame_end_r) st_r <= S_DECODE;
        end
        S_DECODE: begin
          idx_r <= 5'h00;
          txb[0] <= rxb[0];
          if (drop) begin
            st_r <= S_RX;
          end else if (exc != 8'h00) begin
            txb[1] <= fn | EXC_FLAG;
            txb[2] <= exc;
            tx_len_r <= LEN_EXC;
            st_r <= bcast ? S_RX : S_SEND;
          end else if (fn == FN_DIAG) begin
            for (int i = 1; i < 6; i++) txb[i] <= rxb[i];
            tx_len_r <= LEN_ECHO;
            st_r <= bcast ? S_RX : S_SEND;
          end else begin
            txb[1] <= fn;
            // byte count is twice the register count
            txb[2] <= {2'b00, f_n[4:0], 1'b0};
            st_r <= S_REG;
          end
        end
        S_REG: st_r <= S_WAIT;
        S_WAIT: begin
          if (reg_ack) begin
            if (reg_status != 3'h0) begin
              // storage refusal replaces any gathered data
              txb[1] <= fn | EXC_FLAG;
              txb[2] <= {5'h00, reg_status};
              tx_len_r <= LEN_EXC;
              st_r <= bcast ? S_RX : S_SEND;
            end else begin
              if (fn == FN_READ) begin
                // value high byte first, in address order
                txb[3 + 2 * idx_r] <= reg_rdata[15:8];
                txb[4 + 2 * idx_r] <= reg_rdata[7:0];
              end
              if (idx_r + 5'h01 == op_n) begin
                if (fn == FN_READ) begin
                  tx_len_r <= LEN_RD_HDR + {1'b0, op_n, 1'b0};
                end else begin
                  // echo of function, address, value or count
                  for (int i = 1; i < 6; i++) txb[i] <= rxb[i];
                  tx_len_r <= LEN_ECHO;
                end
                st_r <= bcast ? S_RX : S_SEND;
              end else begin
                idx_r <= idx_r + 5'h01;
                st_r <= S_REG;
              end
            end
          end
        end
        S_SEND: begin
          if (tx_done_r) st_r <= S_RX;
        end
        default: st_r <= S_RX;
      endcase
    end
  end

  // ==========================================================
  // Storage port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_addr <= 16'h0000;
      reg_wdata <= 16'h0000;
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
    end else begin
      reg_rd <= st_r == S_REG && fn == FN_READ;
      reg_wr <= st_r == S_REG && fn != FN_READ;
      if (st_r == S_REG) begin
        reg_addr <= f_a + {11'h000, idx_r};
        // single value; values high byte first
        reg_wdata <= (fn == FN_WRITE1) ? f_n
          : {rxb[7 + 2 * idx_r], rxb[8 + 2 * idx_r]};
      end
    end
  end

  // ==========================================================
  // Character transmitter with appended check field
  logic tx_act_r;
  logic [15:0] tx_cnt_r, tx_crc_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  logic [6:0] tx_pos_r;
  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = tx_crc_r[15:8];
    if (tx_pos_r < tx_len_r) tx_byte = txb[tx_pos_r[5:0]];
    else if (tx_pos_r == tx_len_r) tx_byte = tx_crc_r[7:0];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_act_r <= 1'b0;
      tx_done_r <= 1'b0;
      tx_cnt_r <= 16'h0000;
      tx_crc_r <= CRC_INIT;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3ff;
      tx_pos_r <= 7'h00;
      line_out <= 1'b1;
      line_oe_n <= 1'b1;
    end else if (st_r != S_SEND) begin
      tx_act_r <= 1'b0;
      tx_done_r <= 1'b0;
      tx_pos_r <= 7'h00;
      tx_crc_r <= CRC_INIT;
      line_out <= 1'b1;
      line_oe_n <= 1'b1;
    end else if (!tx_act_r) begin
      if (tx_pos_r < tx_len_r + 7'h02) begin
        // start bit, data low bit first, stop bit
        tx_sh_r <= {1'b1, tx_byte, 1'b0};
        line_out <= 1'b0;
        line_oe_n <= 1'b0;
        // check covers the response body only
        if (tx_pos_r < tx_len_r) tx_crc_r <= crc_step(tx_crc_r, tx_byte);
        tx_act_r <= 1'b1;
        tx_cnt_r <= baud_div - 16'h0001;
        tx_bit_r <= 4'h0;
      end else if (!tx_done_r) begin
        // Release the driver only after the last stop bit
        line_oe_n <= 1'b1;
        tx_done_r <= 1'b1;
      end
    end else if (tx_cnt_r != 16'h0000) begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end else if (tx_bit_r == STOP_BIT_IDX) begin
      tx_act_r <= 1'b0;
      tx_pos_r <= tx_pos_r + 7'h01;
    end else begin
      // Stop bit reload is one short: the hand-off to the next byte costs one
      tx_cnt_r <= (tx_bit_r == STOP_BIT_IDX - 4'h1) ? baud_div - 16'h0002
        : baud_div - 16'h0001;
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_sh_r <= tx_sh_r >> 1;
      line_out <= tx_sh_r[1];
    end
  end
endmodule : modbus_rtu_slave
`default_nettype wire

// [tb/modbus_rtu_slave_sva.sv]
// Port checker for the serial command interpreter
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_n,
  input wire logic [7:0] station_addr,
  input wire logic [15:0] baud_div,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] reg_status
);
  import modbus_rtu_pkg::*;
  logic [31:0] idle_r;
  logic [15:0] bit_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helper counters
  // Saturates so a long quiet spell never wraps to zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) idle_r <= '0;
    else if (!line_in) idle_r <= '0;
    else if (idle_r != '1) idle_r <= idle_r + 32'd1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) bit_r <= '0;
    else if (line_oe_n || bit_r == baud_div - 16'd1) bit_r <= '0;
    else bit_r <= bit_r + 16'd1;
  end
  // ==========================================================
  // Properties
  sequence start_bit_s;
    !line_out [*2];
  endsequence
  sequence one_op_s;
    !(reg_rd && reg_wr) ##1 !(reg_rd || reg_wr);
  endsequence
  drive_idle_a: assert property (line_oe_n |-> line_out)
    else $error("line not idle high while released");
  start_bit_a: assert property ($fell(line_oe_n) |-> start_bit_s)
    else $error("reply does not open with a start bit");
  bit_edge_a: assert property (!line_oe_n && $changed(line_out) |->
    bit_r == 16'd0)
    else $error("line changed off a bit boundary");
  release_edge_a: assert property ($rose(line_oe_n) |->
    bit_r == 16'd0 && $past(line_out))
    else $error("driver released mid character");
  frame_gap_a: assert property ($fell(line_oe_n) |->
    idle_r >= 32'(GAP_BITS) * 32'(baud_div))
    else $error("reply started without the idle gap");
  one_op_a: assert property ((reg_rd || reg_wr) |-> one_op_s)
    else $error("storage request not a single pulse");
  addr_hold_a: assert property ($changed(reg_addr) |->
    reg_rd || reg_wr)
    else $error("storage address moved without a request");
  wdata_hold_a: assert property ($changed(reg_wdata) |->
    reg_rd || reg_wr)
    else $error("write value moved without a request");
  quiet_send_a: assert property (!line_oe_n |-> !(reg_rd || reg_wr))
    else $error("storage accessed while replying");
endmodule : modbus_rtu_slave_sva
bind modbus_rtu_slave modbus_rtu_slave_sva chk (.ref_clk(ref_clk),
  .rst(rst), .line_in(line_in), .line_out(line_out),
  .line_oe_n(line_oe_n), .station_addr(station_addr),
  .baud_div(baud_div), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ack(reg_ack),
  .reg_rdata(reg_rdata), .reg_status(reg_status));
`default_nettype wire

// [tb/modbus_master_model.sv]
// Serial master model facing the slave's link
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input wire logic ref_clk,
  input wire logic bus,
  input wire logic line_oe_n,
  input wire logic [15:0] baud_div,
  output logic tx
);
  typedef logic [7:0] byte_q_type [$];
  logic [7:0] rx_q [$];
  event frame_done;
  initial tx = 1'b1;
  function automatic logic [15:0] crc16(input byte_q_type q);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  function automatic byte_q_type with_crc(input byte_q_type q);
    logic [15:0] c;
    c = crc16(q);
    return {q, c[7:0], c[15:8]};
  endfunction : with_crc
  task automatic send(input byte_q_type q, input logic bad);
    byte_q_type f;
    logic [9:0] ch;
    f = with_crc(q);
    if (bad) f[f.size()-1] = ~f[f.size()-1];
    foreach (f[i]) begin
      ch = {1'b1, f[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(posedge ref_clk);
        #1 tx = ch[b];
        repeat (baud_div - 16'd1) @(posedge ref_clk);
      end
    end
  endtask : send
  always begin : receiver
    logic [7:0] b;
    @(negedge line_oe_n);
    rx_q.delete();
    while (line_oe_n === 1'b0) begin
      @(posedge ref_clk);
      if (bus === 1'b0) begin
        repeat (baud_div / 16'd2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (baud_div) @(posedge ref_clk);
          b[i] = bus;
        end
        repeat (baud_div) @(posedge ref_clk);
        rx_q.push_back(b);
      end
    end
    ->frame_done;
  end
endmodule : modbus_master_model
`default_nettype wire

// [tb/modbus_rtu_slave_tb.sv]
// Self-checking bench for the serial command interpreter
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_tb;
  import modbus_rtu_pkg::*;
  typedef logic [7:0] byte_q_type [$];
  localparam logic [15:0] BD = 16'h0010;
  localparam logic [7:0] ME = 8'h11;
  logic ref_clk, rst, m_tx, bus, line_out, line_oe_n;
  logic reg_rd, reg_wr, reg_ack;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, fail_addr, v;
  logic [2:0] reg_status, fail_code;
  logic [31:0] seed;
  logic [15:0] mem [logic [15:0]];
  logic [7:0] exp_q [$];
  int exp_n [$];
  int err_total, checked, rx_cnt, ops, ops0;
  // Bus carries the master's tx whenever the slave's driver is released
  assign bus = line_oe_n ? m_tx : line_out;
  modbus_rtu_slave dut (.ref_clk(ref_clk), .rst(rst), .line_in(bus),
    .line_out(line_out), .line_oe_n(line_oe_n), .station_addr(ME),
    .baud_div(BD), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_status(reg_status));
  modbus_master_model master (.ref_clk(ref_clk), .bus(bus),
    .line_oe_n(line_oe_n), .baud_div(BD), .tx(m_tx));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] rv(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : a ^ 16'h5a5a;
  endfunction : rv
  task automatic cmp(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // Storage and reply monitor
  // Released read data is inverted so stale values cannot pass
  always @(posedge ref_clk) begin : storage
    logic [15:0] a;
    if (reg_rd || reg_wr) begin
      a = reg_addr;
      ops++;
      if (reg_wr) mem[a] = reg_wdata;
      repeat (rnd() % 3) @(posedge ref_clk);
      #1 reg_ack = 1'b1;
      reg_rdata = rv(a);
      reg_status = (a == fail_addr) ? fail_code : 3'h0;
      @(posedge ref_clk);
      #1 reg_ack = 1'b0;
      reg_rdata = ~reg_rdata;
    end
  end
  always @(master.frame_done) begin : monitor
    int n;
    logic [7:0] e, g;
    rx_cnt++;
    n = (exp_n.size() > 0) ? exp_n.pop_front() : 0;
    cmp("reply length", 16'(n), 16'(master.rx_q.size()));
    for (int i = 0; i < n; i++) begin
      e = exp_q.pop_front();
      g = (i < master.rx_q.size()) ? master.rx_q[i] : 8'hxx;
      cmp("reply byte", {8'h00, e}, {8'h00, g});
    end
  end
  // Silent requests simply run out the bounded wait
  task automatic xact(input string name, input byte_q_type req,
                      input byte_q_type rsp, input logic bad);
    int n0;
    n0 = rx_cnt;
    if (rsp.size() > 0) begin
      rsp = master.with_crc(rsp);
      foreach (rsp[i]) exp_q.push_back(rsp[i]);
      exp_n.push_back(rsp.size());
    end
    master.send(req, bad);
    for (int i = 0; i < 200 * BD && rx_cnt == n0; i++) @(posedge ref_clk);
    repeat (36 * BD) @(posedge ref_clk);
    $display("test %s done", name);
  endtask : xact
  // ==========================================================
  // Clock, watchdog and scenarios
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin : watchdog
    repeat (90000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    reg_ack = 1'b0;
    reg_rdata = 16'h0000;
    reg_status = 3'h0;
    fail_addr = 16'hffff;
    fail_code = 3'h0;
    seed = 32'd88553;
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (40 * BD) @(posedge ref_clk);
    xact("read", '{ME, 8'h03, 8'h01, 8'h05, 8'h00, 8'h02}, '{ME, 8'h03,
      8'h04, 8'h5b, 8'h5f, 8'h5b, 8'h5c}, 1'b0);
    for (int n = 0; n < 18; n += 17)
      xact("read count", '{ME, 8'h03, 8'h00, 8'h00, 8'h00, 8'(n)},
        '{ME, 8'h83, EXC_ADDR}, 1'b0);
    xact("read span", '{ME, 8'h03, 8'h01, 8'hfe, 8'h00, 8'h04},
      '{ME, 8'h83, EXC_ADDR}, 1'b0);
    v = 16'(rnd());
    xact("write one", '{ME, 8'h06, 8'h00, 8'h10, v[15:8], v[7:0]},
      '{ME, 8'h06, 8'h00, 8'h10, v[15:8], v[7:0]}, 1'b0);
    cmp("stored single", v, rv(16'h0010));
    v = 16'(rnd());
    xact("write many", '{ME, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02, 8'h04,
      v[15:8], v[7:0], ~v[15:8], ~v[7:0]},
      '{ME, 8'h10, 8'h02, 8'h00, 8'h00, 8'h02}, 1'b0);
    cmp("stored first", v, rv(16'h0200));
    cmp("stored second", ~v, rv(16'h0201));
    xact("byte count", '{ME, 8'h10, 8'h02, 8'h00, 8'h00, 8'h01, 8'h03,
      v[15:8], v[7:0], 8'h00}, '{ME, 8'h90, EXC_ADDR}, 1'b0);
    ops0 = ops;
    xact("loopback", '{ME, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd},
      '{ME, 8'h08, 8'h00, 8'h00, 8'hab, 8'hcd}, 1'b0);
    xact("diag sub", '{ME, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00},
      '{ME, 8'h88, EXC_FUNC}, 1'b0);
    cmp("diag storage ops", 16'(ops0), 16'(ops));
    xact("bad function", '{ME, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01},
      '{ME, 8'h84, EXC_FUNC}, 1'b0);
    xact("bad check", '{ME, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
      '{}, 1'b1);
    for (int s = 8'h12; s < 9'h100; s += 8'he6)
      xact("other station", '{8'(s), 8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
        '{}, 1'b0);
    v = 16'(rnd());
    xact("broadcast", '{ADDR_BCAST, 8'h06, 8'h00, 8'h30, v[15:8], v[7:0]},
      '{}, 1'b0);
    cmp("broadcast stored", v, rv(16'h0030));
    fail_addr = 16'h0077;
    fail_code = 3'h4;
    xact("storage fault", '{ME, 8'h06, 8'h00, 8'h77, 8'h00, 8'h01},
      '{ME, 8'h86, 8'h04}, 1'b0);
    xact("short frame", '{ME, 8'h03, 8'h00, 8'h00, 8'h00},
      '{ME, 8'h83, EXC_FRAME}, 1'b0);
    cmp("pending replies", 16'h0000, 16'(exp_n.size()));
    conclude();
  end
endmodule : modbus_rtu_slave_tb
`default_nettype wire
